//--- inc/rtcx_pkg.sv
/*
 Constants for the RTC auxiliary block: register map, field positions,
 reset values and timing. Assumes a 20 MHz hclk.
*/
package rtcx_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int unsigned HCLK_PERIOD_NS = 50;
   localparam int unsigned LOAD_TIME_NS   = 100_000;
   localparam int unsigned LOAD_CYCLES    = LOAD_TIME_NS / HCLK_PERIOD_NS;
   localparam int unsigned KICK_TIME_NS   = 1_000_000;
   localparam int unsigned KICK_CYCLES    = KICK_TIME_NS / HCLK_PERIOD_NS;
   localparam int unsigned SQW_STAGES     = 16;

   // ------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_CTRL    = 8'h01;
   localparam logic [7:0] IDX_OSC_FAIL_IRQ_EN    = 8'h09;
   localparam logic [7:0] IDX_ALM1MON = 8'h0A;
   localparam logic [7:0] IDX_FLAGS   = 8'h0F;
   localparam logic [7:0] IDX_SQWRATE = 8'h13;
   localparam logic [7:0] IDX_CENTURY = 8'h20;
   localparam logic [7:0] IDX_STATUS  = 8'h21;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int unsigned POS_OSC_STOP  = 7;
   localparam int unsigned POS_OSC_FAIL_IRQ_EN      = 7;
   localparam int unsigned POS_ABE       = 5;
   localparam int unsigned POS_SQUARE_WAVE_EN      = 6;
   localparam int unsigned POS_BL        = 4;
   localparam int unsigned POS_OF        = 2;
   localparam int unsigned POS_RATE_LO   = 0;
   localparam int unsigned POS_ST_BACKUP = 0;
   localparam int unsigned POS_ST_LEAP   = 1;
   localparam int unsigned POS_ST_KICK   = 2;
   localparam int unsigned POS_ST_LOAD   = 3;

   // ------------------------------------------------------------
   // Reset values and calendar limits
   // ------------------------------------------------------------
   localparam logic [3:0] RST_RATE    = 4'h1;
   localparam logic       RST_OF      = 1'b1;
   localparam logic [1:0] RST_CENTURY = 2'h0;
   localparam logic [4:0] HOUR_LAST   = 5'h17;
   localparam logic [4:0] HOUR_FIRST  = 5'h00;
   localparam logic [4:0] FEB_LONG    = 5'h1D;
   localparam logic [4:0] FEB_SHORT   = 5'h1C;

   typedef enum logic {CHK_IDLE, CHK_LOAD} rtcx_chk_t;

endpackage

//--- inc/rtcx_sqw_if.sv
/*
 Link between the register logic and the square-wave divider chain.
 Assumes all signals change on hclk.
*/
`timescale 1ns/1ps
interface rtcx_sqw_if;
   logic [3:0] rate;
   logic       en;
   logic       tick;
   logic       wave;
   modport ctl (output rate, output en, output tick, input wave);
   modport div (input rate, input en, input tick, output wave);
endinterface

//--- logic/rtcx_sqw_div.sv
/*
 Binary divider chain for the square-wave pin.
 Assumes tick pulses once per half period of the 32.768 kHz oscillator.
*/
`timescale 1ns/1ps
module rtcx_sqw_div
   import rtcx_pkg::*;
#(
   parameter int unsigned STAGES = SQW_STAGES
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   rtcx_sqw_if.div   sq
);
   import rtcx_pkg::*;

   logic [STAGES-1:0] chain_ff;
   logic [STAGES-1:0] nxt_chain;
   logic              wave_ff;
   logic              stage_bit;

   generate
      if (STAGES != 16) begin : g_bad
         $error("rtcx_sqw_div needs exactly 16 stages");
      end
   endgenerate

   // ------------------------------------------------------------
   // Divider chain
   // ------------------------------------------------------------
   assign nxt_chain = chain_ff + {{(STAGES-1){1'b0}}, 1'b1};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chain_ff <= '0;
      end else if (sq.tick) begin
         chain_ff <= nxt_chain;
      end
   end

   // Code one taps stage 0, every other code taps its own stage
   always_comb begin
      stage_bit = 1'b0;
      if (sq.rate == 4'h1) begin
         stage_bit = chain_ff[0];
      end else begin
         stage_bit = chain_ff[sq.rate];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wave_ff <= 1'b0;
      end else begin
         wave_ff <= sq.en & stage_bit;
      end
   end

   assign sq.wave = wave_ff;

   a_sqw_gate_off: assert property (@(posedge hclk) disable iff (!hresetn)
      !sq.en |=> !wave_ff) else $error("square wave not off when disabled");

endmodule

//--- logic/rtcx_aux_top.sv
/*
 RTC supporting functions: square-wave control, battery-low check,
 century counter and leap year, oscillator-fail flag and interrupt,
 with an AHB-Lite register slave. Assumes all inputs are synchronous
 to hclk and osc_tick pulses at twice the 32.768 kHz rate.
*/
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module rtcx_aux_top
   import rtcx_pkg::*;
#(
   parameter int unsigned KICK_LEN = KICK_CYCLES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        osc_tick,
   input  wire logic        osc_stopped,
   input  wire logic        on_backup,
   input  wire logic        batt_below,
   input  wire logic [4:0]  hours,
   input  wire logic [7:0]  year_bcd,
   input  wire logic        year_rollover,
   output logic             square_wave_out,
   output logic             batt_load_en,
   output logic             osc_stop_out,
   output logic             osc_kick,
   output logic             leap_year,
   output logic [4:0]       feb_last_day,
   output logic             irq_output_pin_o,
   output logic             irq_output_pin_oe
);
   import rtcx_pkg::*;

   localparam int unsigned KW = $clog2(KICK_LEN + 1);
   localparam int unsigned LW = $clog2(LOAD_CYCLES + 1);

   generate
      if (KICK_LEN < 1) begin : g_bad_kick
         $error("KICK_LEN must be at least one cycle");
      end
   endgenerate

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic bcd_mult4(input logic [7:0] y);
      logic [3:0] u;
      u = y[3:0];
      if (y[4]) begin
         bcd_mult4 = (u == 4'h2) || (u == 4'h6);
      end else begin
         bcd_mult4 = (u == 4'h0) || (u == 4'h4) || (u == 4'h8);
      end
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [3:0]    rate_ff;
   logic          square_wave_en_ff;
   logic          abe_ff;
   logic          osc_fail_irq_en_ff;
   logic          stop_ff;
   logic          of_ff;
   logic          bl_ff;
   logic [1:0]    century_ff;
   logic [4:0]    hours_prev_ff;
   logic          backup_prev_ff;
   rtcx_chk_t     chk_ff;
   logic [LW-1:0] load_cnt_ff;
   logic [KW-1:0] kick_cnt_ff;
   logic          irq_ff;
   logic          wr_pend_ff;
   logic          rd_pend_ff;
   logic [7:0]    addr_idx_ff;
   logic [31:0]   hrdata_ff;
   logic [31:0]   rd_mux;
   logic          take;
   logic          wr_en;
   logic          midnight;
   logic          power_up;
   logic          of_clear;
   logic          stop_fall;
   logic          irq_cond;

   rtcx_sqw_if sqw ();

   // ------------------------------------------------------------
   // AHB-Lite slave: zero-wait writes, one wait state on reads
   // ------------------------------------------------------------
   assign take = hsel && htrans[1] && hready;
   assign wr_en = wr_pend_ff;
   assign hreadyout = !rd_pend_ff;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff  <= 1'b0;
         rd_pend_ff  <= 1'b0;
         addr_idx_ff <= 8'h00;
      end else begin
         wr_pend_ff <= take && hwrite;
         rd_pend_ff <= take && !hwrite;
         if (take) begin
            addr_idx_ff <= haddr[9:2];
         end
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (addr_idx_ff)
         IDX_CTRL:    rd_mux[POS_OSC_STOP] = stop_ff;
         IDX_OSC_FAIL_IRQ_EN:    rd_mux[POS_OSC_FAIL_IRQ_EN] = osc_fail_irq_en_ff;
         IDX_ALM1MON: begin
            rd_mux[POS_ABE]  = abe_ff;
            rd_mux[POS_SQUARE_WAVE_EN] = square_wave_en_ff;
         end
         IDX_FLAGS: begin
            rd_mux[POS_BL] = bl_ff;
            rd_mux[POS_OF] = of_ff;
         end
         IDX_SQWRATE: rd_mux[POS_RATE_LO +: 4] = rate_ff;
         IDX_CENTURY: rd_mux[1:0] = century_ff;
         IDX_STATUS: begin
            rd_mux[POS_ST_BACKUP] = on_backup;
            rd_mux[POS_ST_LEAP]   = leap_year;
            rd_mux[POS_ST_KICK]   = osc_kick;
            rd_mux[POS_ST_LOAD]   = batt_load_en;
         end
         default:     rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data captured in the wait state, so a write just before is seen
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (rd_pend_ff) begin
         hrdata_ff <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rate_ff <= RST_RATE;
         square_wave_en_ff <= 1'b0;
         abe_ff  <= 1'b0;
         osc_fail_irq_en_ff <= 1'b0;
         stop_ff <= 1'b0;
      end else if (wr_en) begin
         unique case (addr_idx_ff)
            IDX_CTRL:    stop_ff <= hwdata[POS_OSC_STOP];
            IDX_OSC_FAIL_IRQ_EN:    osc_fail_irq_en_ff <= hwdata[POS_OSC_FAIL_IRQ_EN];
            IDX_ALM1MON: begin
               abe_ff  <= hwdata[POS_ABE];
               square_wave_en_ff <= hwdata[POS_SQUARE_WAVE_EN];
            end
            IDX_SQWRATE: rate_ff <= hwdata[POS_RATE_LO +: 4];
            default:     rate_ff <= rate_ff;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Square wave
   // ------------------------------------------------------------
   assign sqw.rate = rate_ff;
   assign sqw.en   = square_wave_en_ff && !on_backup && (rate_ff != 4'h0);
   assign sqw.tick = osc_tick;
   assign square_wave_out = sqw.wave;

   rtcx_sqw_div #(.STAGES(SQW_STAGES)) u_div (
      .hclk    (hclk),
      .hresetn (hresetn),
      .sq      (sqw)
   );

   // ------------------------------------------------------------
   // Battery check
   // ------------------------------------------------------------
   assign midnight = (hours_prev_ff == HOUR_LAST) && (hours == HOUR_FIRST);
   // Flop resets high, so leaving reset on main supply counts as power-up
   assign power_up = backup_prev_ff && !on_backup;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hours_prev_ff  <= HOUR_FIRST;
         backup_prev_ff <= 1'b1;
      end else begin
         hours_prev_ff  <= hours;
         backup_prev_ff <= on_backup;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chk_ff      <= CHK_IDLE;
         load_cnt_ff <= '0;
      end else if (on_backup) begin
         chk_ff      <= CHK_IDLE;
         load_cnt_ff <= '0;
      end else begin
         unique case (chk_ff)
            CHK_IDLE: begin
               if (midnight) begin
                  chk_ff      <= CHK_LOAD;
                  load_cnt_ff <= '0;
               end
            end
            CHK_LOAD: begin
               if (load_cnt_ff == LW'(LOAD_CYCLES - 1)) begin
                  chk_ff <= CHK_IDLE;
               end else begin
                  load_cnt_ff <= load_cnt_ff + LW'(1);
               end
            end
         endcase
      end
   end

   assign batt_load_en = (chk_ff == CHK_LOAD);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bl_ff <= 1'b0;
      end else if (!on_backup) begin
         if (power_up && chk_ff == CHK_IDLE) begin
            bl_ff <= batt_below;
         end else if (chk_ff == CHK_LOAD && load_cnt_ff == LW'(LOAD_CYCLES - 1)) begin
            bl_ff <= batt_below;
         end
      end
   end

   // ------------------------------------------------------------
   // Century and leap year
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         century_ff <= RST_CENTURY;
      end else if (year_rollover) begin
         century_ff <= century_ff + 2'h1;
      end else if (wr_en && addr_idx_ff == IDX_CENTURY) begin
         century_ff <= hwdata[1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         leap_year    <= 1'b1;
         feb_last_day <= FEB_LONG;
      end else begin
         leap_year    <= bcd_mult4(year_bcd);
         feb_last_day <= bcd_mult4(year_bcd) ? FEB_LONG : FEB_SHORT;
      end
   end

   // ------------------------------------------------------------
   // Oscillator fail, kick-start and interrupt
   // ------------------------------------------------------------
   assign of_clear  = wr_en && addr_idx_ff == IDX_FLAGS && !hwdata[POS_OF];
   assign stop_fall = wr_en && addr_idx_ff == IDX_CTRL && stop_ff && !hwdata[POS_OSC_STOP];
   assign osc_stop_out = stop_ff;

   // Setting events win over a clear written in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         of_ff <= RST_OF;
      end else if (osc_stopped || stop_ff) begin
         of_ff <= 1'b1;
      end else if (of_clear) begin
         of_ff <= 1'b0;
      end
   end

   // Boost runs a fixed time; the host is trusted to kick only on a set flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         kick_cnt_ff <= '0;
      end else if (stop_fall) begin
         kick_cnt_ff <= KW'(KICK_LEN);
      end else if (kick_cnt_ff != '0) begin
         kick_cnt_ff <= kick_cnt_ff - KW'(1);
      end
   end

   assign osc_kick = (kick_cnt_ff != '0);

   assign irq_cond = of_ff && osc_fail_irq_en_ff && (!on_backup || abe_ff);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= irq_cond;
      end
   end

   // Open drain: only ever pulls low
   assign irq_output_pin_o  = 1'b0;
   assign irq_output_pin_oe = irq_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_sqw_backup_off: assert property (@(posedge hclk) disable iff (!hresetn)
      on_backup |=> !square_wave_out) else $error("square wave active in backup");

   a_of_stays_set: assert property (@(posedge hclk) disable iff (!hresetn)
      of_ff && !of_clear |=> of_ff) else $error("osc fail flag dropped without a clear");

   a_of_stop_sets: assert property (@(posedge hclk) disable iff (!hresetn)
      osc_stopped |=> of_ff) else $error("osc stop did not set flag");

   a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
      of_ff && osc_fail_irq_en_ff && !on_backup |=> irq_output_pin_oe) else $error("interrupt not raised");

   a_irq_backup_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      on_backup && !abe_ff |=> !irq_output_pin_oe) else $error("backup interrupt without enable");

   a_irq_enable_drop: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(osc_fail_irq_en_ff) |=> !irq_output_pin_oe) else $error("interrupt kept");

   a_midnight_load: assert property (@(posedge hclk) disable iff (!hresetn)
      midnight && !on_backup && chk_ff == CHK_IDLE |=> batt_load_en [*8])
      else $error("battery load not applied at midnight");

   a_bl_stable: assert property (@(posedge hclk) disable iff (!hresetn)
      !power_up && chk_ff == CHK_IDLE |=> $stable(bl_ff)) else $error("battery flag changed");

   a_no_chk_backup: assert property (@(posedge hclk) disable iff (!hresetn)
      on_backup |=> !batt_load_en && $stable(bl_ff)) else $error("battery check in backup");

   a_century_step: assert property (@(posedge hclk) disable iff (!hresetn)
      year_rollover |=> century_ff == $past(century_ff) + 2'h1) else $error("century not stepped");

   a_kick_boost: assert property (@(posedge hclk) disable iff (!hresetn)
      stop_fall |=> osc_kick [*2]) else $error("kick boost missing");

   c_midnight_check: cover property (@(posedge hclk) disable iff (!hresetn)
      chk_ff == CHK_LOAD ##1 chk_ff == CHK_IDLE);
   c_irq_raised: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq_output_pin_oe));
   c_kick_start: cover property (@(posedge hclk) disable iff (!hresetn) stop_fall);
   c_century_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
      year_rollover && century_ff == 2'h3);

endmodule

//--- bench/rtcx_host.sv
/*
 Host model that drives the RTC registers over AHB-Lite.
 Assumes a single slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
module rtcx_host
   import rtcx_pkg::*;
#(
   parameter int unsigned RUN_WAIT = 16
) (
   input  wire logic        hclk,
   input  wire logic        hreadyout,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   // ------------------------------------------------------------
   // Single word transfers and oscillator service
   // ------------------------------------------------------------
   initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = {1'b0, 32'h0, 2'h0, 1'b0, 3'h2, 32'h0};

   task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] dat, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? dat : 32'h0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] dat);
      logic [31:0] q;
      xfer(1'b1, idx, dat, q);
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] q);
      xfer(1'b0, idx, 32'h0, q);
   endtask

   // Clearing too soon would hide an oscillator that is still failing
   task automatic clr_of;
      repeat (RUN_WAIT) @(posedge hclk);
      wr(IDX_FLAGS, 32'h0);
   endtask

   task automatic kick(output logic done);
      logic [31:0] f;
      rd(IDX_FLAGS, f);
      done = f[POS_OF];
      if (done) begin
         wr(IDX_CTRL, 32'h80);
         wr(IDX_CTRL, 32'h0);
      end
   endtask
endmodule

//--- bench/testbench.sv
/*
 Self-checking bench for the RTC auxiliary block.
 Assumes the host model drives the bus; oscillator ticks are sped up.
*/
`timescale 1ns/1ps
module testbench;
   import rtcx_pkg::*;
   localparam int unsigned KL = 8;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, osc_tick, osc_stopped, on_backup;
   logic        batt_below, year_rollover, square_wave_out, batt_load_en, osc_stop_out, osc_kick;
   logic        leap_year, irq_output_pin_o, irq_output_pin_oe, d, sq_q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [4:0]  hours, feb_last_day;
   logic [7:0]  year_bcd;
   logic [31:0] haddr, hwdata, hrdata, q;
   int          errors = 0, cmp_count = 0, tog = 0, n, t;
   // ------------------------------------------------------------
   // Design, host and stimulus
   // ------------------------------------------------------------
   rtcx_aux_top #(.KICK_LEN(KL)) DUT (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .osc_tick, .osc_stopped, .on_backup, .batt_below, .hours,
      .year_bcd, .year_rollover, .square_wave_out, .batt_load_en, .osc_stop_out, .osc_kick,
      .leap_year, .feb_last_day, .irq_output_pin_o, .irq_output_pin_oe);
   rtcx_host host (.hclk, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   // Tick every other cycle so the slow rates fit a short run
   always @(posedge hclk) osc_tick <= !osc_tick;
   always @(posedge hclk) begin
      sq_q <= square_wave_out;
      if (square_wave_out !== sq_q) tog <= tog + 1;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Counts load cycles and wave toggles; the comparator flips mid-load
   task automatic span(input int cyc, output int ld, output int tg);
      #1 tg = tog;
      ld = 0;
      repeat (cyc) begin
         @(posedge hclk);
         #1 ld += int'(batt_load_en);
         if (ld == 1000) batt_below = 1'b0;
      end
      tg = tog - tg;
   endtask
   task automatic midnight(output int ld, output int tg);
      hours <= HOUR_LAST;
      @(posedge hclk);
      hours <= HOUR_FIRST;
      span(2100, ld, tg);
   endtask
   task automatic stop_pulse;
      osc_stopped <= 1'b1;
      @(posedge hclk);
      osc_stopped <= 1'b0;
   endtask
   initial begin
      repeat (40000) @(posedge hclk);
      errors++;
      print_verdict;
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      {hresetn, osc_tick, osc_stopped, on_backup, batt_below, year_rollover} = 6'h02;
      {hours, year_bcd} = 13'h0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      host.rd(IDX_FLAGS, q);
      chk(q, 32'h14);
      host.rd(IDX_SQWRATE, q);
      chk(q, 32'h1);
      host.rd(8'h30, q);
      chk(q, 32'h0);
      for (int y = 0; y < 100; y++) begin
         year_bcd <= 8'((y / 10) * 16 + y % 10);
         repeat (3) @(posedge hclk);
         #1 chk(leap_year, 32'(y % 4 == 0));
         chk(feb_last_day, (y % 4 == 0) ? 32'h1D : 32'h1C);
      end
      host.wr(IDX_ALM1MON, 32'h40);
      for (int c = 0; c < 8; c++) begin
         host.wr(IDX_SQWRATE, 32'(c));
         repeat (8) @(posedge hclk);
         span(256, n, t);
         chk(t, (c == 0) ? 0 : (c == 1) ? 128 : 128 >> c);
      end
      host.wr(IDX_SQWRATE, 32'h1);
      host.wr(IDX_ALM1MON, 32'h0);
      repeat (8) @(posedge hclk);
      span(256, n, t);
      chk(t, 0);
      chk(square_wave_out, 1'b0);
      midnight(n, t);
      chk(n, LOAD_CYCLES);
      host.rd(IDX_FLAGS, q);
      chk(q[POS_BL], 1'b0);
      batt_below <= 1'b1;
      host.rd(IDX_FLAGS, q);
      chk(q[POS_BL], 1'b0);
      host.wr(IDX_ALM1MON, 32'h40);
      on_backup <= 1'b1;
      repeat (4) @(posedge hclk);
      midnight(n, t);
      chk(t, 0);
      chk(n, 0);
      host.rd(IDX_FLAGS, q);
      chk(q[POS_BL], 1'b0);
      on_backup <= 1'b0;
      span(20, n, t);
      chk(n, 0);
      host.rd(IDX_FLAGS, q);
      chk(q[POS_BL], 1'b1);
      host.wr(IDX_CENTURY, 32'h3);
      for (int k = 0; k < 2; k++) begin
         year_rollover <= 1'b1;
         @(posedge hclk);
         year_rollover <= 1'b0;
         host.rd(IDX_CENTURY, q);
         chk(q, 32'(k));
      end
      for (int k = 0; k < 3; k++) begin
         host.wr(IDX_OSC_FAIL_IRQ_EN, (k == 1) ? 32'h0 : 32'h80);
         @(posedge hclk);
         #1 chk(irq_output_pin_oe, 32'(k != 1));
      end
      host.rd(IDX_FLAGS, q);
      host.rd(IDX_FLAGS, q);
      chk(q[POS_OF], 1'b1);
      host.clr_of;
      @(posedge hclk);
      #1 chk(irq_output_pin_oe, 1'b0);
      chk(irq_output_pin_o, 1'b0);
      stop_pulse;
      host.rd(IDX_FLAGS, q);
      chk(q[POS_OF], 1'b1);
      host.kick(d);
      #1 n = int'(osc_kick);
      repeat (20) begin
         @(posedge hclk);
         #1 n += int'(osc_kick);
      end
      chk(n, KL);
      chk(d, 1'b1);
      host.clr_of;
      host.kick(d);
      chk(d, 1'b0);
      host.wr(IDX_CTRL, 32'h80);
      @(posedge hclk);
      #1 chk(osc_stop_out, 1'b1);
      host.rd(IDX_FLAGS, q);
      chk(q[POS_OF], 1'b1);
      host.wr(IDX_CTRL, 32'h0);
      on_backup <= 1'b1;
      repeat (2) @(posedge hclk);
      #1 chk(irq_output_pin_oe, 1'b0);
      host.wr(IDX_ALM1MON, 32'h20);
      @(posedge hclk);
      #1 chk(irq_output_pin_oe, 1'b1);
      host.clr_of;
      stop_pulse;
      host.rd(IDX_FLAGS, q);
      chk(q[POS_OF], 1'b1);
      host.rd(IDX_STATUS, q);
      chk(q, 32'h1);
      chk(hresp, 1'b0);
      print_verdict;
   end
endmodule
